// >>> verilog/qlg_pkg.sv
package qlg_pkg;

  localparam int CNT_W = 24;
  localparam int STEP_W = 16;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFF_MODE_LO = 8'h00;
  localparam logic [7:0] OFF_UPPER = 8'h04;
  localparam logic [7:0] OFF_STEP = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  localparam int B_EDGE4X = 24;
  localparam int B_DIR_LO = 25;
  localparam int B_INTV = 27;
  localparam int B_NOREAQ = 28;
  localparam int B_DUAL = 29;
  localparam int B_STEPSEL = 30;
  localparam int B_SYSCLR = 31;
  localparam int B_CLRM_LO = 24;
  localparam int B_VISCLR = 26;
  localparam int B_STEPN_LO = 16;
  localparam int B_PHA = 24;
  localparam int B_PHB = 25;
  localparam int B_DIRUP = 26;
  localparam int B_INTV_IN = 27;
  localparam int B_NEWLN = 28;

  localparam logic [CNT_W-1:0] RST_LIMIT = 24'h000000;
  localparam logic [STEP_W-1:0] RST_STEPN = 16'h0001;

  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_POS = 2'h1;
  localparam logic [1:0] DIR_NEG = 2'h2;
  localparam logic [1:0] CLRM_AUTO = 2'h1;

  typedef struct packed {
    logic valid;
    logic up;
    logic phase_a;
    logic phase_b;
  } qlg_step_s;

endpackage

// >>> verilog/qlg_edge_decode.sv
module qlg_edge_decode (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic dual_phase,
  input wire logic edge4x,
  output qlg_pkg::qlg_step_s step
);

  typedef struct packed {
    logic a_meta;
    logic a_sync;
    logic a_prev;
    logic b_meta;
    logic b_sync;
    logic b_prev;
    logic valid;
    logic up;
  } qlg_dec_s;

  qlg_dec_s q;
  qlg_dec_s d;

  always_comb begin
    logic a_chg;
    logic b_chg;
    logic a_rise;
    logic b_rise;
    a_chg = q.a_sync ^ q.a_prev;
    b_chg = q.b_sync ^ q.b_prev;
    a_rise = a_chg & q.a_sync;
    b_rise = b_chg & q.b_sync;
    d = q;
    d.a_meta = phase_a;
    d.a_sync = q.a_meta;
    d.a_prev = q.a_sync;
    d.b_meta = phase_b;
    d.b_sync = q.b_meta;
    d.b_prev = q.b_sync;
    d.up = 1'b1;
    if (!dual_phase) begin
      d.valid = edge4x ? a_chg : a_rise;
    end else if (edge4x) begin
      // both phases moving at once is a glitch, not a step
      d.valid = a_chg ^ b_chg;
      d.up = a_chg ? (q.a_sync != q.b_sync) : (q.a_sync == q.b_sync);
    end else begin
      d.valid = a_rise ^ b_rise;
      d.up = a_rise ? ~q.b_sync : q.a_sync;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign step.valid = q.valid;
  assign step.up = q.up;
  assign step.phase_a = q.a_sync;
  assign step.phase_b = q.b_sync;

endmodule // qlg_edge_decode

// >>> verilog/qlg_line_gate.sv
// The register addresses and the plain strobed port were chosen for this implementation.
module qlg_line_gate (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  input wire logic NORM_TRIG,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic LINE_TRIG,
  output logic ACQ_TRIG
);

  localparam int W = qlg_pkg::CNT_W;

  typedef struct packed {
    logic [W-1:0] lower;
    logic edge4x;
    logic [1:0] dir_sel;
    logic intv_en;
    logic nore_en;
    logic dual;
    logic step_sel;
    logic [W-1:0] upper;
    logic [1:0] clr_mode;
    logic [qlg_pkg::STEP_W-1:0] step_n;
    logic [W-1:0] count;
    logic dir_up;
    logic in_intv;
    logic new_line;
    logic vis_valid;
    logic [W-1:0] vis_min;
    logic [W-1:0] vis_max;
    logic [qlg_pkg::STEP_W-1:0] step_cnt;
    logic line;
    logic acq_trig;
    logic trig_meta;
    logic trig_sync;
    logic [31:0] rdata;
  } qlg_top_s;

  qlg_top_s q;
  qlg_top_s d;
  qlg_pkg::qlg_step_s step;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic dir_ok(input logic [1:0] sel, input logic up);
    case (sel)
      qlg_pkg::DIR_BOTH: dir_ok = 1'b1;
      qlg_pkg::DIR_POS: dir_ok = up;
      qlg_pkg::DIR_NEG: dir_ok = ~up;
      default: dir_ok = 1'b0;
    endcase
  endfunction

  function automatic logic inside_lim(input logic [W-1:0] v,
      input logic [W-1:0] lo, input logic [W-1:0] hi);
    inside_lim = (v >= lo) && (v <= hi);
  endfunction

  // visited span is kept signed so that backing up past zero stays contiguous
  function automatic logic is_novel(input logic [W-1:0] v, input logic empty,
      input logic [W-1:0] mn, input logic [W-1:0] mx);
    is_novel = empty || ($signed(v) > $signed(mx)) || ($signed(v) < $signed(mn));
  endfunction

  // ----------------------------------------
  // encoder input decode
  // ----------------------------------------
  qlg_edge_decode u_dec (
    .clk_sys(CLK_SYS),
    .resetn(RESETN),
    .phase_a(PHASE_A),
    .phase_b(PHASE_B),
    .dual_phase(q.dual),
    .edge4x(q.edge4x),
    .step(step)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic sys_clr;
  logic vis_clr;
  logic [W-1:0] nc;
  logic nc_in;
  logic nc_novel;
  logic vis_empty;
  logic gate;
  logic leave;
  logic fire;

  always_comb begin
    logic [qlg_pkg::STEP_W-1:0] cnt_inc;
    cnt_inc = q.step_cnt + 16'h0001;
    d = q;
    d.line = 1'b0;
    d.acq_trig = 1'b0;
    d.rdata = 32'h00000000;
    d.trig_meta = NORM_TRIG;
    d.trig_sync = q.trig_meta;

    sys_clr = REG_WR && (REG_ADDR == qlg_pkg::OFF_MODE_LO) && REG_WDATA[qlg_pkg::B_SYSCLR];
    vis_clr = REG_WR && (REG_ADDR == qlg_pkg::OFF_UPPER) && REG_WDATA[qlg_pkg::B_VISCLR];

    nc = step.up ? q.count + 24'h000001 : q.count - 24'h000001;
    nc_in = inside_lim(nc, q.lower, q.upper);
    vis_empty = ~q.vis_valid | vis_clr;
    nc_novel = is_novel(nc, vis_empty, q.vis_min, q.vis_max);

    gate = dir_ok(q.dir_sel, step.up);
    gate = gate && (!q.intv_en || nc_in);
    gate = gate && (!q.nore_en || nc_novel);

    case (q.dir_sel)
      qlg_pkg::DIR_POS: leave = nc > q.upper;
      qlg_pkg::DIR_NEG: leave = nc < q.lower;
      default: leave = !nc_in;
    endcase

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (REG_WR) begin
      case (REG_ADDR)
        qlg_pkg::OFF_MODE_LO: begin
          d.lower = REG_WDATA[W-1:0];
          d.edge4x = REG_WDATA[qlg_pkg::B_EDGE4X];
          d.dir_sel = REG_WDATA[qlg_pkg::B_DIR_LO +: 2];
          d.intv_en = REG_WDATA[qlg_pkg::B_INTV];
          d.nore_en = REG_WDATA[qlg_pkg::B_NOREAQ];
          d.dual = REG_WDATA[qlg_pkg::B_DUAL];
          d.step_sel = REG_WDATA[qlg_pkg::B_STEPSEL];
        end
        qlg_pkg::OFF_UPPER: begin
          d.upper = REG_WDATA[W-1:0];
          d.clr_mode = REG_WDATA[qlg_pkg::B_CLRM_LO +: 2];
        end
        qlg_pkg::OFF_STEP: begin
          d.step_n = REG_WDATA[qlg_pkg::B_STEPN_LO +: qlg_pkg::STEP_W];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // position and visited record
    // ----------------------------------------
    // record held until cleared
    if (vis_clr) begin
      d.vis_valid = 1'b0;
    end
    if (step.valid) begin
      d.count = nc;
      d.dir_up = step.up;
      d.in_intv = nc_in;
      d.new_line = nc_novel;
      d.line = gate;
      d.vis_valid = 1'b1;
      if (vis_empty) begin
        d.vis_min = nc;
        d.vis_max = nc;
      end else if ($signed(nc) > $signed(q.vis_max)) begin
        d.vis_max = nc;
      end else if ($signed(nc) < $signed(q.vis_min)) begin
        d.vis_min = nc;
      end
      if (q.clr_mode == qlg_pkg::CLRM_AUTO && leave) begin
        d.vis_valid = 1'b0;
      end
    end

    // ----------------------------------------
    // scan step
    // ----------------------------------------
    // a step count of zero behaves like one: every gated line fires
    fire = 1'b0;
    if (q.line) begin
      if (cnt_inc >= q.step_n) begin
        fire = 1'b1;
        d.step_cnt = 16'h0000;
      end else begin
        d.step_cnt = cnt_inc;
      end
    end
    d.acq_trig = q.step_sel ? fire : q.trig_sync;

    if (sys_clr) begin
      d.count = 24'h000000;
      d.vis_valid = 1'b0;
      d.step_cnt = 16'h0000;
      d.line = 1'b0;
      d.in_intv = 1'b0;
      d.new_line = 1'b1;
      d.dir_up = 1'b1;
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    if (REG_RD) begin
      case (REG_ADDR)
        qlg_pkg::OFF_MODE_LO: begin
          d.rdata = {1'b0, q.step_sel, q.dual, q.nore_en, q.intv_en,
                     q.dir_sel, q.edge4x, q.lower};
        end
        qlg_pkg::OFF_UPPER: begin
          d.rdata = {6'h00, q.clr_mode, q.upper};
        end
        qlg_pkg::OFF_STEP: begin
          d.rdata = {q.step_n, q.step_cnt};
        end
        qlg_pkg::OFF_STATUS: begin
          d.rdata = {3'h0, q.new_line, q.in_intv, q.dir_up,
                     step.phase_b, step.phase_a, q.count};
        end
        default: begin
          d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.lower <= qlg_pkg::RST_LIMIT;
      q.upper <= qlg_pkg::RST_LIMIT;
      q.step_n <= qlg_pkg::RST_STEPN;
      q.dir_up <= 1'b1;
      q.new_line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign LINE_TRIG = q.line;
  assign ACQ_TRIG = q.acq_trig;

  logic cnt_fire_ok;
  assign cnt_fire_ok = (q.step_cnt + 16'h0001) >= q.step_n && !sys_clr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  sequence s_step_fwd;
    step.valid && step.up && !sys_clr;
  endsequence

  sequence s_quiet;
    !step.valid && !sys_clr;
  endsequence

  sequence s_unmapped_rd;
    REG_RD && (REG_ADDR > qlg_pkg::OFF_STATUS);
  endsequence

  sequence s_step_live;
    step.valid && !sys_clr;
  endsequence

  AST_COUNT_UP: assert property (s_step_fwd |=> q.count == $past(q.count) + 24'h000001)
    else $error("count did not advance");
  AST_COUNT_HOLD: assert property (s_quiet |=> q.count == $past(q.count))
    else $error("count moved without a step");
  AST_LINE_CAUSE: assert property (q.line |-> $past(step.valid) && !$past(sys_clr))
    else $error("line without encoder step");
  AST_DIR_POS: assert property (step.valid && !step.up && q.dir_sel == qlg_pkg::DIR_POS
      |=> !q.line)
    else $error("line on negative step in positive mode");
  AST_INTV_BLOCK: assert property (step.valid && q.intv_en && !nc_in |=> !q.line)
    else $error("line outside interval");
  AST_NO_REVISIT: assert property (step.valid && q.nore_en && !nc_novel |=> !q.line)
    else $error("line on visited value");
  AST_FREE_LINE: assert property (step.valid && !sys_clr && q.dir_sel == qlg_pkg::DIR_BOTH
      && !q.intv_en && !q.nore_en |=> q.line)
    else $error("permitted change gave no line");
  AST_SYS_CLR: assert property (sys_clr |=> q.count == 24'h000000 && !q.vis_valid
      && q.step_cnt == 16'h0000)
    else $error("system clear incomplete");
  AST_VIS_CLR: assert property (vis_clr && !step.valid |=> !q.vis_valid)
    else $error("visited clear ignored");
  // the step direction was decided from the type bit one cycle earlier
  AST_SINGLE_UP: assert property (!$past(q.dual) && step.valid |-> step.up)
    else $error("single phase counted down");
  AST_STEP_SRC: assert property (q.step_sel && q.line && cnt_fire_ok |=> ACQ_TRIG)
    else $error("scan step trigger missing");
  AST_RD_ZERO: assert property (s_unmapped_rd |=> REG_RDATA == 32'h00000000)
    else $error("unmapped read not zero");
  AST_DIR_NEG: assert property (step.valid && step.up && q.dir_sel == qlg_pkg::DIR_NEG
      |=> !q.line)
    else $error("line on positive step in negative mode");
  AST_DIR_RSVD: assert property (step.valid && q.dir_sel == 2'h3 |=> !q.line)
    else $error("line with reserved direction code");
  AST_INTV_PASS: assert property (s_step_live ##0 (q.dir_sel == qlg_pkg::DIR_BOTH
      && q.intv_en && nc_in && !q.nore_en) |=> q.line)
    else $error("line missing inside interval");
  AST_AUTO_CLR: assert property (s_step_live ##0 (q.clr_mode == qlg_pkg::CLRM_AUTO && leave)
      |=> !q.vis_valid)
    else $error("automatic clear missed on leaving interval");
  AST_VIS_KEEP: assert property (q.vis_valid && !vis_clr && !sys_clr
      && !(step.valid && q.clr_mode == qlg_pkg::CLRM_AUTO && leave) |=> q.vis_valid)
    else $error("visited record lost without a clear");
  AST_STEP_HOLD: assert property (!q.line && !sys_clr |=> q.step_cnt == $past(q.step_cnt))
    else $error("step count moved without a line");
  AST_NORM_SRC: assert property (!q.step_sel |=> ACQ_TRIG == $past(q.trig_sync))
    else $error("normal trigger not passed through");
  AST_LOWER_WR: assert property (REG_WR && REG_ADDR == qlg_pkg::OFF_MODE_LO
      |=> q.lower == $past(REG_WDATA[W-1:0]))
    else $error("lower limit write lost");
  AST_UPPER_WR: assert property (REG_WR && REG_ADDR == qlg_pkg::OFF_UPPER
      |=> q.upper == $past(REG_WDATA[W-1:0]))
    else $error("upper limit write lost");
  AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
    else $error("read data outside its cycle");
  AST_CLR_LINE: assert property (sys_clr |=> !q.line)
    else $error("line after system clear");

endmodule // qlg_line_gate

// >>> verification/qlg_enc_model.sv
module qlg_enc_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step_req,
  input wire logic step_up,
  output logic phase_a,
  output logic phase_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos_q;
  // ----------------------------------------
  // shaft position
  // ----------------------------------------
  // gray order, a leads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 2'h0;
    end else if (step_req) begin
      pos_q <= step_up ? pos_q + 2'h1 : pos_q - 2'h1;
    end
  end
  assign phase_a = pos_q[1] ^ pos_q[0];
  assign phase_b = pos_q[1];
endmodule // qlg_enc_model

// >>> verification/quadrature_line_gating_tb.sv
module quadrature_line_gating_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] upw;
    logic [31:0] u1;
    logic [31:0] d;
    logic [31:0] u2;
    logic [31:0] nl;
    logic [31:0] cnt;
  } qlg_row_s;
  logic CLK_SYS = 1'b0;
  logic RESETN = 1'b0;
  logic NORM_TRIG = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h00000000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic LINE_TRIG;
  logic ACQ_TRIG;
  logic PHASE_A;
  logic PHASE_B;
  logic step_req = 1'b0;
  logic step_up = 1'b0;
  logic [31:0] rv;
  int n_errors = 0;
  int comparisons = 0;
  int n_lines = 0;
  int n_acq = 0;
  // ----------------------------------------
  // cases: config, upper word, up, down, up, lines, count
  // ----------------------------------------
  qlg_row_s rows [13] = '{
    '{32'h21000000, 32'h00000000, 6, 2, 0, 8, 4},
    '{32'h23000000, 32'h00000000, 6, 2, 0, 6, 4},
    '{32'h25000000, 32'h00000000, 6, 2, 0, 2, 4},
    '{32'h27000000, 32'h00000000, 6, 2, 0, 0, 4},
    '{32'h31000000, 32'h00000000, 6, 2, 4, 8, 8},
    '{32'h20000000, 32'h00000000, 8, 0, 0, 4, 4},
    '{32'h01000000, 32'h00000000, 4, 4, 0, 4, 4},
    '{32'h29000003, 32'h00000005, 8, 0, 0, 3, 8},
    '{32'h2B000003, 32'h00000005, 8, 8, 0, 3, 0},
    '{32'h2D000003, 32'h00000005, 8, 8, 0, 3, 0},
    '{32'h39000002, 32'h00000005, 8, 8, 8, 4, 8},
    '{32'h39000002, 32'h01000005, 8, 8, 8, 12, 8},
    '{32'h39000002, 32'h02000005, 8, 8, 8, 4, 8}
  };
  qlg_line_gate qlg_line_gate_inst (
    .CLK_SYS(CLK_SYS),
    .RESETN(RESETN),
    .PHASE_A(PHASE_A),
    .PHASE_B(PHASE_B),
    .NORM_TRIG(NORM_TRIG),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .LINE_TRIG(LINE_TRIG),
    .ACQ_TRIG(ACQ_TRIG)
  );
  qlg_enc_model qlg_enc_model_inst (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .step_req(step_req),
    .step_up(step_up),
    .phase_a(PHASE_A),
    .phase_b(PHASE_B)
  );
  initial begin
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    if (LINE_TRIG === 1'b1) n_lines++;
    if (ACQ_TRIG === 1'b1) n_acq++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // steps spaced 7 cycles so every phase holds well past the sync
  task automatic move(input logic [31:0] n, input logic up);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_SYS);
      step_req <= 1'b1;
      step_up <= up;
      @(posedge CLK_SYS);
      step_req <= 1'b0;
      repeat (5) @(posedge CLK_SYS);
    end
    repeat (8) @(posedge CLK_SYS);
  endtask
  task automatic setup(input logic [31:0] cfg, input logic [31:0] upw);
    wr(8'h04, upw);
    wr(8'h00, cfg | 32'h80000000);
    repeat (4) @(posedge CLK_SYS);
    n_lines = 0;
    n_acq = 0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(8'h00, rv);
    chk("lower after reset", 32'h00000000, rv);
    rd(8'h08, rv);
    chk("step after reset", 32'h00010000, rv);
    rd(8'h0C, rv);
    chk("count after reset", 32'h00000000, rv & 32'h00FFFFFF);
    wr(8'h0C, 32'h00ABCDEF);
    rd(8'h10, rv);
    chk("unmapped read", 32'h00000000, rv);
    foreach (rows[i]) begin
      setup(rows[i].cfg, rows[i].upw);
      rd(8'h04, rv);
      chk("upper word", rows[i].upw & 32'h03FFFFFF, rv);
      move(rows[i].u1, 1'b1);
      move(rows[i].d, 1'b0);
      move(rows[i].u2, 1'b1);
      chk("lines", rows[i].nl, n_lines);
      rd(8'h0C, rv);
      chk("count", rows[i].cnt, rv & 32'h00FFFFFF);
    end
    wr(8'h00, 32'h80000000);
    rd(8'h0C, rv);
    chk("count after clear", 32'h00000000, rv & 32'h00FFFFFF);
    setup(32'h31000000, 32'h00000000);
    move(4, 1'b1);
    move(4, 1'b0);
    // zero was never stepped onto, so backing down to it is a new value
    chk("lines first pass", 5, n_lines);
    wr(8'h04, 32'h04000000);
    n_lines = 0;
    move(4, 1'b1);
    chk("lines after visited clear", 4, n_lines);
    rd(8'h0C, rv);
    chk("status after clear", 32'h14000004, rv);
    wr(8'h08, 32'h00030000);
    setup(32'h61000000, 32'h00000000);
    move(7, 1'b1);
    chk("step lines", 7, n_lines);
    chk("step triggers", 2, n_acq);
    wr(8'h00, 32'h21000000);
    NORM_TRIG <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    chk("normal trigger", 32'h00000001, {31'h0, ACQ_TRIG});
    NORM_TRIG <= 1'b0;
    // reset again in mid-run: registers and triggers go back
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    chk("triggers in reset", 32'h00000000, {30'h0, LINE_TRIG, ACQ_TRIG});
    rd(8'h00, rv);
    chk("mode after second reset", 32'h00000000, rv);
    rd(8'h08, rv);
    chk("step after second reset", 32'h00010000, rv);
    rd(8'h0C, rv);
    chk("status after second reset", 32'h14000000, rv);
    @(posedge CLK_SYS);
    #1 chk("read data after its cycle", 32'h00000000, REG_RDATA);
    finish_test();
  end
endmodule // quadrature_line_gating_tb
